// [src/ccr_pkg.sv]
package ccr_pkg;
  localparam logic [7:0] REG_INPUT_SRC  = 8'h00;
  localparam logic [7:0] REG_DATA_LINE  = 8'h01;
  localparam logic [7:0] REG_ADC_DETECT = 8'h02;
  localparam logic [7:0] REG_LAST       = 8'h14;
  localparam logic [7:0] RD_BEYOND      = 8'hFF;
  localparam logic [7:0] RST_INPUT_SRC  = 8'h48;
  localparam logic [7:0] RST_DATA_LINE  = 8'h01;
  localparam logic [7:0] RST_ADC_DETECT = 8'h1D;
  localparam int HIZ_BIT = 7;
  localparam int EXTLIM_BIT = 6;
  localparam int TWELVE_BIT = 1;
  localparam int DPMOS_BIT = 0;
  localparam int ADCST_BIT = 7;
  localparam int ADCCONT_BIT = 6;
  localparam int BFREQ_BIT = 5;
  localparam int ICO_BIT = 4;
  localparam int HIGH_VOLTAGE_CHARGER_PORT_BIT = 3;
  localparam int ADJ_BIT = 2;
  localparam int FDET_BIT = 1;
  localparam int AUTO_BIT = 0;
  localparam logic [2:0] LVL_SHORT = 3'h7;
  // input current limit codes, 50mA per step above a 100mA floor
  // the floor is what lets the all-ones code reach 3.25A and the reset code mean 500mA
  localparam logic [5:0] EXT_LIMIT_PIN_500  = 6'h08;
  localparam logic [5:0] EXT_LIMIT_PIN_1000 = 6'h12;
  localparam logic [5:0] EXT_LIMIT_PIN_1500 = 6'h1C;
  localparam logic [5:0] EXT_LIMIT_PIN_2000 = 6'h26;
  localparam logic [5:0] EXT_LIMIT_PIN_2100 = 6'h28;
  localparam logic [5:0] EXT_LIMIT_PIN_2400 = 6'h2E;
  localparam logic [5:0] EXT_LIMIT_PIN_3250 = 6'h3F;
  typedef enum logic [3:0] {
    SRC_SDP, SRC_CDP, SRC_DCP, SRC_ADJ_HV, SRC_UNKNOWN,
    SRC_NS_1A, SRC_NS_2A, SRC_NS_2A1, SRC_NS_2A4, SRC_PSEL
  } ccr_src_e;
endpackage

// [src/ccr_regs.sv]
`timescale 1ns/1ns
// Operation
// - reg 0x00 bit 7 high-impedance enable, cleared by register reset or watchdog
// - reg 0x00 bit 6 external limit pin enable, default 1, both resets
// - reg 0x00 bits 5:0 input current limit, only register reset restores
// - detection variant loads limit by detected source type
// - select-pin detection: high gives 500mA, low gives 3.25A
// - reg 0x01 bits 7:5 select D+ driver level, default 000
// - reg 0x01 bits 4:2 D- level, 110 and 111 both 3.3V
// - D+ code 111 shorts D+ to D-; both driver level outputs keep their written codes
// - reg 0x01 bit 1 requests 12V, software only, default 0
// - reg 0x01 bit 0 DPM offset, default 1, software only
// - writing 1 starts ADC; reads 1 while converting or detecting
// - continuous mode makes ADC start bit read-only
// - reg 0x02 bit 6 selects one-shot or 1s continuous conversion
// - reg 0x02 bit 5 boost frequency, default 0, both resets
// - boost frequency writes ignored while boost output enabled
// - reg 0x02 bit 4 optimizer enable, default 1, register reset only
// - reg 0x02 bit 3 high-voltage charger handshake enable, default 1
// - reg 0x02 bit 2 adjustable adapter handshake enable, default 1
// - writing 1 forces detection; reads 0 when idle; both resets
// - reg 0x02 bit 0 enables automatic detection on plug-in
// - watchdog keeps input limit and DPM settings
// - reads beyond 0x14 return 0xFF
module ccr_regs
  import ccr_pkg::*;
#(
  parameter bit HAS_DPDM = 1'b1
)(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWdata,
  output logic [7:0]             regRdata,
  output logic                   regAck,
  input  wire logic              registerReset,
  input  wire logic              watchdogExpire,
  input  wire logic              boostOutputEnable,
  input  wire logic              powerSelectPin,
  input  wire logic              vbusPlugIn,
  input  wire logic              adcBusy,
  input  wire logic              adcTick,
  input  wire logic              detectDone,
  input  wire ccr_pkg::ccr_src_e detectType,
  output logic                   inputHizEnable,
  output logic                   extLimitPinEnable,
  output logic [5:0]             inputCurrentLimit,
  output logic [2:0]             dpDriverLevel,
  output logic [2:0]             dmDriverLevel,
  output logic                   dataLineShort,
  output logic                   twelveVoltRequest,
  output logic                   inputVoltageDpmOffset,
  output logic                   adcStartPulse,
  output logic                   adcContinuous,
  output logic                   boostSwitchFreq,
  output logic                   inputOptimizerEnable,
  output logic                   hvHandshakeEnable,
  output logic                   adjHandshakeEnable,
  output logic                   detectStart
);
  import ccr_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pselSync_r;
  logic [1:0] plugSync_r;
  logic       plugSeen_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pselSync_r <= 2'h0;
      plugSync_r <= 2'h0;
      plugSeen_r <= 1'b0;
    end else begin
      pselSync_r <= {pselSync_r[0], powerSelectPin};
      plugSync_r <= {plugSync_r[0], vbusPlugIn};
      plugSeen_r <= plugSync_r[1];
    end
  end
  wire plugRise = plugSync_r[1] & ~plugSeen_r;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] srcReg_r, srcReg_nxt;
  logic [7:0] lineReg_r, lineReg_nxt;
  logic [7:0] adcReg_r, adcReg_nxt;
  logic       adcActive_r, adcActive_nxt;
  logic       detActive_r, detActive_nxt;

  wire wrSrc  = regWrite & (regAddr == REG_INPUT_SRC);
  wire wrLine = regWrite & (regAddr == REG_DATA_LINE);
  wire wrAdc  = regWrite & (regAddr == REG_ADC_DETECT);
  wire contMode = adcReg_r[ADCCONT_BIT];
  wire startReq = wrAdc & regWdata[ADCST_BIT] & ~contMode;
  wire forceReq = wrAdc & regWdata[FDET_BIT];
  wire autoReq  = plugRise & adcReg_r[AUTO_BIT];
  wire detReq   = HAS_DPDM & (forceReq | autoReq);

  logic [5:0] detLimit;
  ccr_source_limit u_limit (
    .srcType         (detectType),
    .powerSelectHigh (pselSync_r[1]),
    .limitCode       (detLimit)
  );

  // ----------------------------------------------------------------
  // next-state
  // ----------------------------------------------------------------
  always_comb begin
    srcReg_nxt    = srcReg_r;
    lineReg_nxt   = lineReg_r;
    adcReg_nxt    = adcReg_r;
    adcActive_nxt = adcActive_r;
    detActive_nxt = detActive_r;
    if (wrSrc) begin
      srcReg_nxt = regWdata;
    end
    if (wrLine) begin
      lineReg_nxt = regWdata;
    end
    if (wrAdc) begin
      adcReg_nxt[ADCCONT_BIT:0] = regWdata[ADCCONT_BIT:0];
      adcReg_nxt[FDET_BIT] = 1'b0;
      if (boostOutputEnable) begin
        adcReg_nxt[BFREQ_BIT] = adcReg_r[BFREQ_BIT];
      end
    end
    adcReg_nxt[ADCST_BIT] = 1'b0;
    // completion first so a new request in the same cycle still wins
    if (detectDone) begin
      detActive_nxt = 1'b0;
      if (HAS_DPDM) begin
        srcReg_nxt[5:0] = detLimit;
      end
    end
    if (!adcBusy && !startReq) begin
      adcActive_nxt = 1'b0;
    end
    if (startReq || (contMode && adcTick)) begin
      adcActive_nxt = 1'b1;
    end
    if (detReq) begin
      detActive_nxt = 1'b1;
    end
    if (watchdogExpire) begin
      // limit and DPM offset survive the watchdog
      srcReg_nxt[HIZ_BIT]    = RST_INPUT_SRC[HIZ_BIT];
      srcReg_nxt[EXTLIM_BIT] = RST_INPUT_SRC[EXTLIM_BIT];
      adcReg_nxt[ADCCONT_BIT:BFREQ_BIT] = RST_ADC_DETECT[ADCCONT_BIT:BFREQ_BIT];
      adcActive_nxt = 1'b0;
      detActive_nxt = 1'b0;
    end
    if (registerReset) begin
      srcReg_nxt = RST_INPUT_SRC;
      adcReg_nxt = RST_ADC_DETECT;
      adcActive_nxt = 1'b0;
      detActive_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srcReg_r    <= RST_INPUT_SRC;
      lineReg_r   <= RST_DATA_LINE;
      adcReg_r    <= RST_ADC_DETECT;
      adcActive_r <= 1'b0;
      detActive_r <= 1'b0;
    end else begin
      srcReg_r    <= srcReg_nxt;
      lineReg_r   <= lineReg_nxt;
      adcReg_r    <= adcReg_nxt;
      adcActive_r <= adcActive_nxt;
      detActive_r <= detActive_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [7:0] adcView = {adcActive_r | detActive_r, adcReg_r[ADCCONT_BIT:AUTO_BIT + 2],
                        detActive_r, adcReg_r[AUTO_BIT]};
  logic [7:0] rdMux;
  always_comb begin
    if (regAddr == REG_INPUT_SRC) begin
      rdMux = srcReg_r;
    end else if (regAddr == REG_DATA_LINE) begin
      rdMux = lineReg_r;
    end else if (regAddr == REG_ADC_DETECT) begin
      rdMux = adcView;
    end else if (regAddr > REG_LAST) begin
      rdMux = RD_BEYOND;
    end else begin
      rdMux = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  wire shortReq = (lineReg_nxt[7:5] == LVL_SHORT);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata              <= 8'h00;
      regAck                <= 1'b0;
      inputHizEnable        <= RST_INPUT_SRC[HIZ_BIT];
      extLimitPinEnable     <= RST_INPUT_SRC[EXTLIM_BIT];
      inputCurrentLimit     <= RST_INPUT_SRC[5:0];
      dpDriverLevel         <= RST_DATA_LINE[7:5];
      dmDriverLevel         <= RST_DATA_LINE[4:2];
      dataLineShort         <= 1'b0;
      twelveVoltRequest     <= RST_DATA_LINE[TWELVE_BIT];
      inputVoltageDpmOffset <= RST_DATA_LINE[DPMOS_BIT];
      adcStartPulse         <= 1'b0;
      adcContinuous         <= RST_ADC_DETECT[ADCCONT_BIT];
      boostSwitchFreq       <= RST_ADC_DETECT[BFREQ_BIT];
      inputOptimizerEnable  <= RST_ADC_DETECT[ICO_BIT];
      hvHandshakeEnable     <= RST_ADC_DETECT[HIGH_VOLTAGE_CHARGER_PORT_BIT];
      adjHandshakeEnable    <= RST_ADC_DETECT[ADJ_BIT];
      detectStart           <= 1'b0;
    end else begin
      regRdata              <= regRead ? rdMux : regRdata;
      regAck                <= regRead | regWrite;
      inputHizEnable        <= srcReg_nxt[HIZ_BIT];
      extLimitPinEnable     <= srcReg_nxt[EXTLIM_BIT];
      inputCurrentLimit     <= srcReg_nxt[5:0];
      dpDriverLevel         <= lineReg_nxt[7:5];
      dmDriverLevel         <= lineReg_nxt[4:2];
      dataLineShort         <= shortReq;
      twelveVoltRequest     <= lineReg_nxt[TWELVE_BIT];
      inputVoltageDpmOffset <= lineReg_nxt[DPMOS_BIT];
      adcStartPulse         <= (startReq | (contMode & adcTick)) & ~registerReset
                               & ~watchdogExpire;
      adcContinuous         <= adcReg_nxt[ADCCONT_BIT];
      boostSwitchFreq       <= adcReg_nxt[BFREQ_BIT];
      inputOptimizerEnable  <= adcReg_nxt[ICO_BIT];
      hvHandshakeEnable     <= HAS_DPDM & adcReg_nxt[HIGH_VOLTAGE_CHARGER_PORT_BIT];
      adjHandshakeEnable    <= HAS_DPDM & adcReg_nxt[ADJ_BIT];
      detectStart           <= detReq & ~registerReset & ~watchdogExpire;
    end
  end
endmodule

// [src/ccr_source_limit.sv]
`timescale 1ns/1ns
// maps detected source to an input current limit code
module ccr_source_limit
  import ccr_pkg::*;
(
  input  wire ccr_pkg::ccr_src_e srcType,
  input  wire logic              powerSelectHigh,
  output logic [5:0]             limitCode
);
  import ccr_pkg::*;

  always_comb begin
    unique case (srcType)
      SRC_SDP:     limitCode = EXT_LIMIT_PIN_500;
      SRC_CDP:     limitCode = EXT_LIMIT_PIN_1500;
      SRC_DCP:     limitCode = EXT_LIMIT_PIN_3250;
      SRC_ADJ_HV:  limitCode = EXT_LIMIT_PIN_1500;
      SRC_UNKNOWN: limitCode = EXT_LIMIT_PIN_500;
      SRC_NS_1A:   limitCode = EXT_LIMIT_PIN_1000;
      SRC_NS_2A:   limitCode = EXT_LIMIT_PIN_2000;
      SRC_NS_2A1:  limitCode = EXT_LIMIT_PIN_2100;
      SRC_NS_2A4:  limitCode = EXT_LIMIT_PIN_2400;
      SRC_PSEL:    limitCode = powerSelectHigh ? EXT_LIMIT_PIN_500 : EXT_LIMIT_PIN_3250;
      default:     limitCode = EXT_LIMIT_PIN_500;
    endcase
  end
endmodule

// [verif/ccr_host_model.sv]
`timescale 1ns/1ns
module ccr_host_model (
  input  wire logic       clk,
  input  wire logic       regAck,
  input  wire logic [7:0] regRdata,
  output logic            regWrite,
  output logic            regRead,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWdata
);
  logic timedOut = 1'b0;
  initial begin
    {regWrite, regRead, regAddr, regWdata} = 18'h0;
  end
  // request is sampled once, so it stands one edge; bus inverted after release
  task automatic access(input logic rd, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk);
    {regRead, regWrite, regAddr, regWdata} <= {rd, !rd, a, d};
    @(posedge clk);
    {regRead, regWrite, regAddr, regWdata} <= {2'b00, ~a, ~d};
    q = 8'h00;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      if (regAck === 1'b1) begin
        q = regRdata;
        return;
      end
    end
    timedOut = 1'b1;
  endtask
endmodule

// [verif/ccr_regs_monitor.sv]
`timescale 1ns/1ns
module ccr_regs_monitor
  import ccr_pkg::*;
(
  input wire logic       clk, rst_n, regWrite, regRead, registerReset, watchdogExpire,
  input wire logic       boostOutputEnable, adcTick, detectDone, inputHizEnable,
  input wire logic       extLimitPinEnable, dataLineShort, inputVoltageDpmOffset,
  input wire logic       adcStartPulse, adcContinuous, boostSwitchFreq,
  input wire logic [7:0] regAddr, regWdata, regRdata,
  input wire logic [5:0] inputCurrentLimit,
  input wire logic [2:0] dpDriverLevel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] wdP;
  always_ff @(posedge clk) wdP <= regWdata;
  // writes racing a reset or detection result are skipped; only a register reset race is judged elsewhere, by reg_reset_a
  wire calm = !registerReset && !watchdogExpire && !detectDone;
  wire wr0 = regWrite && regAddr == REG_INPUT_SRC && calm;
  wire wr2 = regWrite && regAddr == REG_ADC_DETECT && calm;
  beyond_read_a: assert property (regRead && regAddr > REG_LAST |=> regRdata == RD_BEYOND)
    else $error("read beyond map");
  hiz_write_a: assert property (wr0 |=> {inputHizEnable, extLimitPinEnable} == wdP[7:6])
    else $error("enable bits not written");
  limit_write_a: assert property (wr0 |=> inputCurrentLimit == wdP[5:0])
    else $error("limit not written");
  short_code_a: assert property (dataLineShort == (dpDriverLevel == LVL_SHORT))
    else $error("short flag wrong");
  reg_reset_a: assert property (registerReset && !detectDone |=> !inputHizEnable &&
    extLimitPinEnable && inputCurrentLimit == RST_INPUT_SRC[5:0] && !boostSwitchFreq)
    else $error("register reset incomplete");
  wdog_keep_a: assert property (watchdogExpire && !registerReset && !regWrite && !detectDone
    |=> $stable(inputCurrentLimit) && $stable(inputVoltageDpmOffset) && !adcContinuous)
    else $error("watchdog reset wrong");
  boost_hold_a: assert property (wr2 && boostOutputEnable |=> $stable(boostSwitchFreq))
    else $error("boost frequency changed");
  adc_ro_a: assert property (wr2 && adcContinuous && regWdata[6] && !adcTick |=> !adcStartPulse)
    else $error("start taken in continuous mode");
  adc_start_a: assert property (wr2 && regWdata[7:6] == 2'b10 && !adcContinuous |=> adcStartPulse)
    else $error("no conversion start");
  cover property (wr2 && boostOutputEnable);
  cover property (watchdogExpire);
  cover property (detectDone);
endmodule
bind ccr_regs ccr_regs_monitor i_mon (.clk, .rst_n, .regWrite, .regRead, .registerReset,
  .watchdogExpire, .boostOutputEnable, .adcTick, .detectDone, .inputHizEnable, .extLimitPinEnable,
  .dataLineShort, .inputVoltageDpmOffset, .adcStartPulse, .adcContinuous, .boostSwitchFreq,
  .regAddr, .regWdata, .regRdata, .inputCurrentLimit, .dpDriverLevel);

// [verif/testbench.sv]
`timescale 1ns/1ns
module testbench;
  import ccr_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, registerReset = 1'b0, watchdogExpire = 1'b0;
  logic       boostOutputEnable = 1'b0, powerSelectPin = 1'b0, vbusPlugIn = 1'b0;
  logic       adcBusy = 1'b0, adcTick = 1'b0, detectDone = 1'b0;
  logic       regWrite, regRead, regAck, inputHizEnable, extLimitPinEnable, dataLineShort;
  logic       twelveVoltRequest, inputVoltageDpmOffset, adcStartPulse, adcContinuous;
  logic       boostSwitchFreq, inputOptimizerEnable, hvHandshakeEnable, adjHandshakeEnable;
  logic       detectStart, hit;
  logic [7:0] regAddr, regWdata, regRdata;
  logic [5:0] inputCurrentLimit;
  logic [2:0] dpDriverLevel, dmDriverLevel;
  ccr_src_e   detectType = SRC_SDP;
  int         n_errors = 0;
  int         n_checks = 0;
  always #25 clk = ~clk;
  ccr_regs i_dut (.clk, .rst_n, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regAck,
    .registerReset, .watchdogExpire, .boostOutputEnable, .powerSelectPin, .vbusPlugIn, .adcBusy,
    .adcTick, .detectDone, .detectType, .inputHizEnable, .extLimitPinEnable, .inputCurrentLimit,
    .dpDriverLevel, .dmDriverLevel, .dataLineShort, .twelveVoltRequest, .inputVoltageDpmOffset,
    .adcStartPulse, .adcContinuous, .boostSwitchFreq, .inputOptimizerEnable, .hvHandshakeEnable,
    .adjHandshakeEnable, .detectStart);
  ccr_host_model i_host (.clk, .regAck, .regRdata, .regWrite, .regRead, .regAddr, .regWdata);
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(logic rd, logic [7:0] a, d, exp);
    logic [7:0] q;
    i_host.access(rd, a, d, q);
    if (i_host.timedOut) begin
      n_errors++;
      conclude();
    end
    if (rd) chk($sformatf("reg %h", a), q, exp);
  endtask
  // one-cycle event pulse; returns at the falling edge so outputs are settled
  task automatic strobe(int which, ccr_src_e s);
    @(posedge clk);
    {registerReset, watchdogExpire, adcTick} <= 3'b100 >> which;
    detectDone <= (which == 3);
    detectType <= s;
    @(posedge clk);
    {registerReset, watchdogExpire, adcTick, detectDone} <= 4'h0;
    @(negedge clk);
  endtask
  task automatic t_regs();
    xfer(1, 8'h00, 0, 8'h48);
    xfer(1, 8'h01, 0, 8'h01);
    xfer(1, 8'h02, 0, 8'h1D);
    xfer(1, 8'h15, 0, 8'hFF);
    xfer(0, 8'h00, 8'hBF, 0);
    chk("limit", inputCurrentLimit, 8'h3F);
    for (int c = 0; c < 8; c++) begin
      xfer(0, 8'h01, {c[2:0], c[2:0], 2'b10}, 0);
      chk("dp", dpDriverLevel, c[2:0]);
      chk("dm", dmDriverLevel, c[2:0]);
      chk("short", dataLineShort, c == 7);
    end
    chk("dpm", {twelveVoltRequest, inputVoltageDpmOffset}, 8'h02);
    $display("register test end");
  endtask
  task automatic t_resets();
    xfer(0, 8'h00, 8'h95, 0);
    xfer(0, 8'h02, 8'h20, 0);
    strobe(1, SRC_SDP);
    xfer(1, 8'h00, 0, 8'h55);
    xfer(1, 8'h01, 0, 8'hFE);
    xfer(1, 8'h02, 0, 8'h00);
    chk("enables", {inputOptimizerEnable, hvHandshakeEnable, adjHandshakeEnable}, 8'h00);
    strobe(0, SRC_SDP);
    xfer(1, 8'h00, 0, 8'h48);
    xfer(1, 8'h01, 0, 8'hFE);
    xfer(1, 8'h02, 0, 8'h1D);
    chk("enables", {inputOptimizerEnable, hvHandshakeEnable, adjHandshakeEnable}, 8'h07);
    boostOutputEnable <= 1'b1;
    xfer(0, 8'h02, 8'h3D, 0);
    xfer(1, 8'h02, 0, 8'h1D);
    boostOutputEnable <= 1'b0;
    xfer(0, 8'h02, 8'h3D, 0);
    chk("boost", boostSwitchFreq, 8'h01);
    $display("reset test end");
  endtask
  task automatic t_adc();
    adcBusy <= 1'b1;
    xfer(0, 8'h02, 8'h9D, 0);
    xfer(1, 8'h02, 0, 8'h9D);
    adcBusy <= 1'b0;
    xfer(1, 8'h02, 0, 8'h1D);
    xfer(0, 8'h02, 8'h5D, 0);
    xfer(0, 8'h02, 8'hDD, 0);
    xfer(1, 8'h02, 0, 8'h5D);
    strobe(2, SRC_SDP);
    chk("tick start", adcStartPulse, 8'h01);
    xfer(0, 8'h02, 8'h1D, 0);
    $display("adc test end");
  endtask
  task automatic t_detect();
    ccr_src_e   s[9] = '{SRC_SDP, SRC_CDP, SRC_DCP, SRC_ADJ_HV, SRC_UNKNOWN, SRC_NS_1A,
                         SRC_NS_2A, SRC_NS_2A1, SRC_NS_2A4};
    logic [5:0] l[9] = '{EXT_LIMIT_PIN_500, EXT_LIMIT_PIN_1500, EXT_LIMIT_PIN_3250, EXT_LIMIT_PIN_1500, EXT_LIMIT_PIN_500, EXT_LIMIT_PIN_1000,
                         EXT_LIMIT_PIN_2000, EXT_LIMIT_PIN_2100, EXT_LIMIT_PIN_2400};
    for (int i = 0; i < 11; i++) begin
      if (i > 8) @(posedge clk) powerSelectPin <= (i == 9);
      repeat (4) @(posedge clk);
      strobe(3, i > 8 ? SRC_PSEL : s[i]);
      chk("source limit", inputCurrentLimit, i > 8 ? (i == 9 ? EXT_LIMIT_PIN_500 : EXT_LIMIT_PIN_3250) : l[i]);
    end
    xfer(0, 8'h02, 8'h1F, 0);
    xfer(1, 8'h02, 0, 8'h9F);
    strobe(3, SRC_DCP);
    xfer(1, 8'h02, 0, 8'h1D);
    for (int e = 1; e >= 0; e--) begin
      xfer(0, 8'h02, {7'h0E, e[0]}, 0);
      @(posedge clk) vbusPlugIn <= 1'b1;
      hit = 1'b0;
      repeat (8) @(posedge clk) hit |= detectStart;
      chk("auto detect", hit, e[0]);
      @(posedge clk) vbusPlugIn <= 1'b0;
      strobe(3, SRC_SDP);
      repeat (4) @(posedge clk);
    end
    $display("detect test end");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_resets();
    t_adc();
    t_detect();
    conclude();
  end
endmodule
